// ### hdl/pps_cfg.svh
// pps_cfg.svh: register indices, field positions, reset values and timing figures for the parallel ports.
// assumes it is included by bare name wherever a constant is needed.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// register indices; byte address on the bus is four times the index
`define PPS_IDX_FIVE_DIR 8'h01
`define PPS_IDX_FIVE_DATA 8'h03
`define PPS_IDX_EIGHT_DIR 8'h04
`define PPS_IDX_EIGHT_DATA 8'h06
`define PPS_IDX_EIGHT_CSR 8'h0f
`define PPS_IDX_INT_STATUS 8'h20
`define PPS_IDX_INT_MASK 8'h21

// control and status field positions of the eight-line port
`define PPS_CSR_FLAG 7
`define PPS_CSR_IE 6
`define PPS_CSR_OSS 4
`define PPS_CSR_LE 3

// sticky event bits of the interrupt status and mask registers
`define PPS_INT_W 2
`define PPS_INT_IS 0
`define PPS_INT_OS 1

// operating mode codes that count as single-chip
`define PPS_MODE_SINGLE 3'h7
`define PPS_MODE_SINGLE_TEST 3'h4

// cycles the mode straps are left to settle through the synchroniser
`define PPS_MODE_WAIT 2'h3

// reset values
`define PPS_DIR_RESET 8'h00
`define PPS_DATA_RESET 8'h00
`define PPS_WORD_ZERO 32'h0000_0000

// output strobe low time in ns and the clock period in ns
`define PPS_OS_LOW_NS 1000
`define PPS_CLK_NS 20

`endif

// ### hdl/pps_pkg.sv
// pps_pkg: types shared by the parallel port design.
// assumes pps_cfg.svh for numeric constants.
package pps_pkg;

  // control bits of the eight-line port, kept as one carrier
  typedef struct packed {
    logic flag;
    logic ie;
    logic strobe_source_select;
    logic le;
  } pps_csr_t;

  // decoded bus request
  typedef struct packed {
    logic [7:0] idx;
    logic wr;
    logic [7:0] wdata;
  } pps_req_t;

  // mode capture sequence after reset release
  typedef enum logic {
    PPS_ST_SAMPLE,
    PPS_ST_RUN
  } pps_state_t;

endpackage

// ### hdl/pps_sync.sv
// pps_sync: two-flop synchroniser for a group of pins.
// assumes the pins are asynchronous to pclk; each bit is treated alone.
`timescale 1ns/100ps
module pps_sync import pps_pkg::*; #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule // pps_sync

// ### hdl/pps_strobe.sv
// pps_strobe: stretches a one-cycle trigger into a low pulse of fixed length.
// assumes triggers come from logic on pclk; a trigger during a pulse restarts it.
`timescale 1ns/100ps
module pps_strobe import pps_pkg::*; #(
  parameter int LOW_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger,
  output logic strobe_n
);

  localparam int CW = $clog2(LOW_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(LOW_CYCLES);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic strobe_n_d;

  // count down the low time; restart keeps a late access from being lost
  always_comb begin
    count_d = count_q;
    if (trigger) begin
      count_d = LOAD;
    end else if (count_q != '0) begin
      count_d = count_q - CW'(1);
    end
    strobe_n_d = (count_d == '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      strobe_n <= 1'b1;
    end else begin
      count_q <= count_d;
      strobe_n <= strobe_n_d;
    end
  end

endmodule // pps_strobe

// ### hdl/pps_top.sv
// pps_top: five-line mode-strap port and eight-line strobed port behind an APB slave.
// assumes one 50 MHz clock; pins arrive asynchronously and go through two flops first.
// Function
// RULE1: five-line port works alike in every mode
// RULE2: sample three low lines at reset release
// RULE3: all five lines are inputs after sampling
// RULE4: each direction bit makes its line output
// RULE5: data register drives outputs, reads line values
// RULE6: line one output follows timer compare level
// RULE7: lines shared with serial and capture logic
// RULE8: eight-line port is plain I/O in single-chip
// RULE9: strobe options work only in single-chip mode
// RULE10: latch input data on input strobe fall
// RULE11: pulse output strobe on data register access
// RULE12: strobe fall raises enabled maskable interrupt
// RULE13: select clear means read, set means write
// RULE14: direction one is output, zero is input
// RULE15: peripheral strobes data ready or accepted
// RULE16: flag7, enable6, select4, latch3, others unused
// RULE17: flag set by fall, cleared by read-then-access
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "pps_cfg.svh"
module pps_top import pps_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int OS_LOW_CYCLES = (`PPS_OS_LOW_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] five_in,
  output logic [4:0] five_out,
  output logic [4:0] five_oe,
  input wire logic [7:0] eight_in,
  output logic [7:0] eight_out,
  output logic [7:0] eight_oe,
  input wire logic input_strobe_n,
  output logic output_strobe_n,
  input wire logic compare_level,
  input wire logic sci_tx_enable,
  input wire logic sci_tx_level,
  output logic capture_edge_level,
  output logic sci_rx_level,
  output logic [2:0] mode,
  output logic single_chip,
  output logic maskable_interrupt_line
);

  // true when a bus address selects the given register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (addr[1:0] == 2'b00);
  endfunction

  // synchronised pins
  logic [4:0] five_sync;
  logic [7:0] eight_sync;
  logic strobe_sync;

  pps_sync #(.W(5)) u_sync_five (
    .pclk(pclk),
    .presetn(presetn),
    .din(five_in),
    .dout(five_sync)
  );

  pps_sync #(.W(8)) u_sync_eight (
    .pclk(pclk),
    .presetn(presetn),
    .din(eight_in),
    .dout(eight_sync)
  );

  // strobe is synchronised active high so the flops' reset value is the idle level and no false fall follows reset
  pps_sync #(.W(1)) u_sync_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .din(~input_strobe_n),
    .dout(strobe_sync)
  );

  // mode capture state
  pps_state_t state_q, state_d;
  logic [1:0] wait_q, wait_d;
  logic [2:0] mode_q, mode_d;
  logic single_d;

  // the straps are read only once the synchroniser has filled with real pin levels
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    mode_d = mode_q;
    unique case (state_q)
      PPS_ST_SAMPLE: begin
        if (wait_q == `PPS_MODE_WAIT) begin
          mode_d = five_sync[2:0]; // see RULE2
          state_d = PPS_ST_RUN;
        end else begin
          wait_d = wait_q + 2'd1;
        end
      end
      PPS_ST_RUN: begin
        state_d = PPS_ST_RUN;
      end
    endcase
    single_d = (state_d == PPS_ST_RUN) &&
               ((mode_d == `PPS_MODE_SINGLE) || (mode_d == `PPS_MODE_SINGLE_TEST));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PPS_ST_SAMPLE;
      wait_q <= 2'd0;
      mode_q <= 3'h0;
      single_chip <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      mode_q <= mode_d;
      single_chip <= single_d;
    end
  end

  // bus phases: setup prepares the answer, access commits side effects
  pps_req_t req;
  logic setup;
  logic access;
  logic mapped;
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign req = '{idx: paddr[9:2], wr: pwrite, wdata: pwdata[7:0]};
  assign mapped = reg_hit(paddr, `PPS_IDX_FIVE_DIR) || reg_hit(paddr, `PPS_IDX_FIVE_DATA) ||
                  reg_hit(paddr, `PPS_IDX_EIGHT_DIR) || reg_hit(paddr, `PPS_IDX_EIGHT_DATA) ||
                  reg_hit(paddr, `PPS_IDX_EIGHT_CSR) || reg_hit(paddr, `PPS_IDX_INT_STATUS) ||
                  reg_hit(paddr, `PPS_IDX_INT_MASK);

  // port and control state
  logic [4:0] five_dir_q, five_dir_d;
  logic [4:0] five_data_q, five_data_d;
  logic [7:0] eight_dir_q, eight_dir_d;
  logic [7:0] eight_data_q, eight_data_d;
  logic [7:0] latch_q, latch_d;
  logic latch_full_q, latch_full_d;
  pps_csr_t csr_q, csr_d;
  logic armed_q, armed_d;
  logic strobe_prev_q;
  logic [`PPS_INT_W-1:0] int_stat_q, int_stat_d;
  logic [`PPS_INT_W-1:0] int_mask_q, int_mask_d;
  logic strobe_fall;
  logic os_trigger;
  logic data_access;
  logic data_read;

  assign strobe_fall = !strobe_prev_q && strobe_sync; // pin fall seen as a rise of the inverted copy
  assign data_access = access && reg_hit(paddr, `PPS_IDX_EIGHT_DATA);
  assign data_read = data_access && !req.wr;
  // strobe source follows the select bit, and only in single-chip mode
  assign os_trigger = single_chip && data_access && (req.wr == csr_q.strobe_source_select); // see RULE11 see RULE13 see RULE9

  // register writes and the side effects of bus accesses
  always_comb begin
    five_dir_d = five_dir_q;
    five_data_d = five_data_q;
    eight_dir_d = eight_dir_q;
    eight_data_d = eight_data_q;
    csr_d = csr_q;
    int_mask_d = int_mask_q;
    int_stat_d = int_stat_q;
    latch_d = latch_q;
    latch_full_d = latch_full_q;
    armed_d = armed_q;
    if (access && req.wr) begin
      if (reg_hit(paddr, `PPS_IDX_FIVE_DIR)) begin
        five_dir_d = req.wdata[4:0]; // see RULE4 see RULE14
      end
      if (reg_hit(paddr, `PPS_IDX_FIVE_DATA)) begin
        five_data_d = req.wdata[4:0]; // see RULE5
      end
      if (reg_hit(paddr, `PPS_IDX_EIGHT_DIR)) begin
        eight_dir_d = req.wdata; // see RULE8 see RULE14
      end
      if (reg_hit(paddr, `PPS_IDX_EIGHT_DATA)) begin
        eight_data_d = req.wdata;
      end
      if (reg_hit(paddr, `PPS_IDX_EIGHT_CSR)) begin
        csr_d.ie = req.wdata[`PPS_CSR_IE]; // see RULE16
        csr_d.strobe_source_select = req.wdata[`PPS_CSR_OSS];
        csr_d.le = req.wdata[`PPS_CSR_LE];
      end
      if (reg_hit(paddr, `PPS_IDX_INT_MASK)) begin
        int_mask_d = pwdata[`PPS_INT_W-1:0];
      end
      if (reg_hit(paddr, `PPS_IDX_INT_STATUS)) begin
        int_stat_d = int_stat_q & ~pwdata[`PPS_INT_W-1:0];
      end
    end
    // reading the status with the flag up arms the clear; a data access completes it
    if (access && !req.wr && reg_hit(paddr, `PPS_IDX_EIGHT_CSR) && csr_q.flag) begin
      armed_d = 1'b1; // see RULE17
    end
    if (data_access && armed_q) begin
      csr_d.flag = 1'b0; // see RULE17
      armed_d = 1'b0;
    end
    // a read of the data register lets the latch follow the pins again
    if (data_read) begin
      latch_full_d = 1'b0;
    end
    // edge events win over a clear in the same cycle
    if (strobe_fall) begin
      csr_d.flag = 1'b1; // see RULE17 see RULE15
      armed_d = 1'b0;
      int_stat_d[`PPS_INT_IS] = 1'b1;
      if (single_chip && csr_q.le && (!latch_full_q || data_read)) begin
        latch_d = eight_sync; // see RULE10 see RULE9
        latch_full_d = 1'b1;
      end
    end
    if (os_trigger) begin
      int_stat_d[`PPS_INT_OS] = 1'b1;
    end
    // with latching off nothing is held
    if (!csr_d.le) begin
      latch_full_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      five_dir_q <= 5'h00; // see RULE3
      five_data_q <= 5'h00;
      eight_dir_q <= `PPS_DIR_RESET;
      eight_data_q <= `PPS_DATA_RESET;
      latch_q <= `PPS_DATA_RESET;
      latch_full_q <= 1'b0;
      csr_q <= '0; // see RULE17
      armed_q <= 1'b0;
      strobe_prev_q <= 1'b0;
      int_stat_q <= '0;
      int_mask_q <= '0;
    end else begin
      five_dir_q <= five_dir_d;
      five_data_q <= five_data_d;
      eight_dir_q <= eight_dir_d;
      eight_data_q <= eight_data_d;
      latch_q <= latch_d;
      latch_full_q <= latch_full_d;
      csr_q <= csr_d;
      armed_q <= armed_d;
      strobe_prev_q <= strobe_sync;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
    end
  end

  // bus answer: no wait state, ready and data are registered in setup so every answer leaves a flop
  logic [31:0] rdata_d;
  logic [7:0] eight_view;

  always_comb begin
    // input lines show the held byte while the latch is full
    eight_view = (eight_dir_q & eight_data_q) |
                 (~eight_dir_q & (latch_full_q ? latch_q : eight_sync));
    rdata_d = `PPS_WORD_ZERO;
    if (setup && !pwrite) begin
      if (reg_hit(paddr, `PPS_IDX_FIVE_DIR)) begin
        rdata_d[4:0] = five_dir_q;
      end
      if (reg_hit(paddr, `PPS_IDX_FIVE_DATA)) begin
        rdata_d[7:0] = {mode_q, five_sync}; // see RULE5 see RULE1
      end
      if (reg_hit(paddr, `PPS_IDX_EIGHT_DIR)) begin
        rdata_d[7:0] = eight_dir_q;
      end
      if (reg_hit(paddr, `PPS_IDX_EIGHT_DATA)) begin
        rdata_d[7:0] = eight_view;
      end
      if (reg_hit(paddr, `PPS_IDX_EIGHT_CSR)) begin
        rdata_d[`PPS_CSR_FLAG] = csr_q.flag; // see RULE16
        rdata_d[`PPS_CSR_IE] = csr_q.ie;
        rdata_d[`PPS_CSR_OSS] = csr_q.strobe_source_select;
        rdata_d[`PPS_CSR_LE] = csr_q.le;
      end
      if (reg_hit(paddr, `PPS_IDX_INT_STATUS)) begin
        rdata_d[`PPS_INT_W-1:0] = int_stat_q;
      end
      if (reg_hit(paddr, `PPS_IDX_INT_MASK)) begin
        rdata_d[`PPS_INT_W-1:0] = int_mask_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PPS_WORD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata_d;
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // pin drive, interrupt and shared-function outputs
  logic [4:0] five_out_d, five_oe_d;
  logic [7:0] eight_out_d, eight_oe_d;
  logic irq_d;

  always_comb begin
    five_out_d = five_data_q;
    five_oe_d = five_dir_q; // see RULE4 see RULE1
    if (five_dir_q[1]) begin
      five_out_d[1] = compare_level; // see RULE6
    end
    // serial transmit borrows the top line while it is enabled
    if (sci_tx_enable) begin
      five_out_d[4] = sci_tx_level; // see RULE7
      five_oe_d[4] = 1'b1;
    end
    // outside single-chip the port belongs to the bus, which this block does not drive
    eight_out_d = eight_data_q;
    eight_oe_d = single_chip ? eight_dir_q : 8'h00; // see RULE8
    irq_d = (single_chip && csr_q.ie && csr_q.flag) || |(int_stat_q & int_mask_q); // see RULE12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      five_out <= 5'h00;
      five_oe <= 5'h00;
      eight_out <= `PPS_DATA_RESET;
      eight_oe <= `PPS_DIR_RESET;
      capture_edge_level <= 1'b0;
      sci_rx_level <= 1'b0;
      maskable_interrupt_line <= 1'b0;
    end else begin
      five_out <= five_out_d;
      five_oe <= five_oe_d;
      eight_out <= eight_out_d;
      eight_oe <= eight_oe_d;
      capture_edge_level <= five_sync[0]; // see RULE7
      sci_rx_level <= five_sync[3];
      maskable_interrupt_line <= irq_d;
    end
  end

  assign mode = mode_q;

  // output strobe pulse generator
  pps_strobe #(.LOW_CYCLES(OS_LOW_CYCLES)) u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(os_trigger),
    .strobe_n(output_strobe_n)
  );

endmodule // pps_top

// ### test/pps_top_asserts.sv
// pps_top_asserts: port-level checker for the parallel port block, bound into pps_top.
// assumes a single pclk domain and presetn as the only reset.
`timescale 1ns/100ps
module pps_top_asserts import pps_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int OS_LOW_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] five_out,
  input wire logic [4:0] five_oe,
  input wire logic [7:0] eight_oe,
  input wire logic output_strobe_n,
  input wire logic compare_level,
  input wire logic single_chip
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic oss_q;
  logic oss_d;
  assign acc = psel && penable && pready;
  // shadow of the strobe select bit, so the trigger direction can be judged
  always_comb begin
    oss_d = oss_q;
    if (acc && pwrite && paddr == 12'h03c) oss_d = pwdata[4];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oss_q <= 1'b0;
    else oss_q <= oss_d;
  end
  // strobe steps: qualifying data access, then a held low pulse (sim width is 3)
  sequence s_os_acc;
    acc && paddr == 12'h018 && single_chip && pwrite == oss_q;
  endsequence
  sequence s_os_low;
    !output_strobe_n [*3];
  endsequence
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_os_trig; s_os_acc |-> ##[1:3] s_os_low; endproperty
  a_os_trig: assert property (p_os_trig) else $error("output strobe missing");
  property p_os_mode; $fell(output_strobe_n) |-> $past(single_chip); endproperty
  a_os_mode: assert property (p_os_mode) else $error("strobe outside single-chip");
  property p_rst_in; $rose(presetn) |-> (five_oe == 5'h00 && eight_oe == 8'h00) [*4]; endproperty
  a_rst_in: assert property (p_rst_in) else $error("lines not inputs after reset");
  property p_eight_single; eight_oe != 8'h00 |-> single_chip; endproperty
  a_eight_single: assert property (p_eight_single) else $error("eight port driven in expanded mode");
  property p_compare; five_oe[1] |-> five_out[1] == $past(compare_level); endproperty
  a_compare: assert property (p_compare) else $error("line one not following compare");
endmodule // pps_top_asserts

bind pps_top pps_top_asserts #(.ADDR_W(ADDR_W), .OS_LOW_CYCLES(OS_LOW_CYCLES)) pps_top_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .five_out(five_out), .five_oe(five_oe),
  .eight_oe(eight_oe), .output_strobe_n(output_strobe_n), .compare_level(compare_level),
  .single_chip(single_chip)
);

// ### test/pps_periph.sv
// pps_periph: external peripheral on the eight-line port, strobing data in and counting strobes out.
// assumes the bench calls send from a process synchronous to pclk.
`timescale 1ns/100ps
module pps_periph import pps_pkg::*; (
  input wire logic pclk,
  input wire logic [7:0] eight_out,
  input wire logic [7:0] eight_oe,
  input wire logic output_strobe_n,
  output logic [7:0] eight_in,
  output logic input_strobe_n,
  output int acks
);
  logic [7:0] data_q;
  initial begin
    data_q = 8'h00;
    input_strobe_n = 1'b1;
    acks = 0;
  end
  // wired level: lines the device drives show its value, the rest ours
  assign eight_in = (eight_oe & eight_out) | (~eight_oe & data_q);
  // each output strobe counts as one acknowledgement
  always @(negedge output_strobe_n) acks <= acks + 1;
  // data ready: present data, then hold the strobe low long enough for two sync flops
  task automatic send(input logic [7:0] d);
    @(posedge pclk);
    data_q <= d;
    @(posedge pclk);
    input_strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    input_strobe_n <= 1'b1;
    data_q <= ~d; // hold over: show a different value so stale data is caught
  endtask
endmodule // pps_periph

// ### test/pps_top_tb.sv
// pps_top_tb: register-level tests of the parallel port block over APB.
// assumes pps_top, pps_periph and the bound checker are compiled before it.
`timescale 1ns/100ps
module pps_top_tb import pps_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, compare_level, sci_tx_enable, sci_tx_level, err;
  logic pready, pslverr, output_strobe_n, input_strobe_n, capture_edge_level, sci_rx_level;
  logic single_chip, maskable_interrupt_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] five_in, five_out, five_oe, five_drv;
  logic [7:0] eight_in, eight_out, eight_oe, rd;
  logic [2:0] mode;
  int acks, num_errors, tests_run;
  // undriven five-port lines show the bench's pin levels
  assign five_in = (five_oe & five_out) | (~five_oe & five_drv);
  pps_top #(.OS_LOW_CYCLES(3)) pps_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .five_in(five_in), .five_out(five_out), .five_oe(five_oe), .eight_in(eight_in), .eight_out(eight_out),
    .eight_oe(eight_oe), .input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n),
    .compare_level(compare_level), .sci_tx_enable(sci_tx_enable), .sci_tx_level(sci_tx_level),
    .capture_edge_level(capture_edge_level), .sci_rx_level(sci_rx_level), .mode(mode),
    .single_chip(single_chip), .maskable_interrupt_line(maskable_interrupt_line));
  pps_periph pps_periph_i (.pclk(pclk), .eight_out(eight_out), .eight_oe(eight_oe),
    .output_strobe_n(output_strobe_n), .eight_in(eight_in), .input_strobe_n(input_strobe_n), .acks(acks));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one APB transfer; starts after an edge so it never collides with the last release
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  // let registered pin outputs land before looking at them
  task automatic settle;
    repeat (4) @(negedge pclk);
  endtask
  task automatic rst(input logic [2:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    sci_tx_enable <= 1'b0;
    five_drv <= {2'b00, s};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, sci_tx_enable, sci_tx_level} = 6'h00;
    compare_level = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    five_drv = 5'h00;
    num_errors = 0;
    tests_run = 0;
    rst(3'h7);
    five_drv <= 5'h0d;
    settle();
    chk({mode, single_chip}, 4'hf);
    chk({capture_edge_level, sci_rx_level}, 2'b11);
    rdc(8'h03, 8'hed);
    rdc(8'h01, 8'h00);
    rdc(8'h0f, 8'h00);
    $display("test reset_mode done");
    sci_tx_enable <= 1'b1;
    wr(8'h01, 8'h1f);
    wr(8'h03, 8'h15);
    settle();
    chk(five_oe, 5'h1f);
    chk(five_out, 5'h07);
    @(posedge pclk) compare_level <= 1'b0;
    settle();
    chk(five_out, 5'h05);
    wr(8'h01, 8'h04);
    settle();
    chk(five_oe, 5'h14);
    $display("test five_port done");
    wr(8'h04, 8'hf0);
    wr(8'h06, 8'ha5);
    settle();
    chk(eight_oe, 8'hf0);
    chk(eight_out & eight_oe, 8'ha0);
    wr(8'h0f, 8'h48);
    pps_periph_i.send(8'h3c);
    settle();
    chk(maskable_interrupt_line, 1'b1);
    rdc(8'h0f, 8'hc8);
    rdc(8'h06, 8'hac);
    rdc(8'h0f, 8'h48);
    rdc(8'h06, 8'ha3);
    settle();
    chk(maskable_interrupt_line, 1'b0);
    chk(acks, 2);
    wr(8'h0f, 8'h10);
    wr(8'h06, 8'h5a);
    rdc(8'h06, 8'h53);
    settle();
    chk(acks, 3);
    $display("test eight_port done");
    rdc(8'h20, 8'h03);
    wr(8'h21, 8'h01);
    settle();
    chk(maskable_interrupt_line, 1'b1);
    wr(8'h20, 8'h01);
    settle();
    chk(maskable_interrupt_line, 1'b0);
    rdc(8'h20, 8'h02);
    apb(1'b0, 8'h05, 8'h00);
    chk({err, rd}, 9'h100);
    $display("test interrupt done");
    rst(3'h2);
    chk({mode, single_chip}, 4'h4);
    wr(8'h04, 8'hff);
    apb(1'b0, 8'h06, 8'h00);
    settle();
    chk(eight_oe, 8'h00);
    chk(acks, 3);
    $display("test expanded_mode done");
    print_verdict();
  end
endmodule // pps_top_tb
